// ==== vicr_pkg.sv ====
package vicr_pkg;

    // Register offsets, byte addresses; each has aliases at +4/+8/+C
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SHDW   = 8'h10;
    localparam logic [7:0] OFS_STAT   = 8'h20;
    localparam logic [7:0] OFS_RELOAD = 8'h30;
    localparam logic [7:0] OFS_FLAG   = 8'h40;
    localparam logic [7:0] OFS_ENAB   = 8'h50;
    localparam logic [7:0] OFS_PRIO   = 8'h60;

    // Alias operation in address bits 3:2
    localparam logic [1:0] OP_WR  = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;

    // Writable bit masks, all other bits read as zero
    localparam logic [31:0] CTRL_MASK   = 32'h007F171F;
    localparam logic [31:0] SHDW_MASK   = 32'hFFFFFFF1;
    localparam logic [31:0] RELOAD_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] SRC_MASK    = 32'h000000FF;
    localparam logic [31:0] PRIO_MASK   = 32'h00FFFFFF;

    // Field positions
    localparam int VS_LSB     = 16;
    localparam int VS_W       = 7;
    localparam int MULTI_VECTOR_SELECT_BIT   = 12;
    localparam int TPC_LSB    = 8;
    localparam int SRIPL_LSB  = 8;
    localparam int SHDW_FLD_W = 4;
    localparam int SS0_BIT    = 0;
    localparam int PRIO_W     = 3;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h00000000;
    localparam logic [31:0] SHDW_RST   = 32'h00000000;
    localparam logic [31:0] RELOAD_RST = 32'h00000000;

    // Sizes and vector spacing unit
    localparam int         NUM_SRC      = 8;
    localparam int         NUM_EXT      = 5;
    localparam logic [9:0] SPACING_UNIT = 10'h008;
    // Edges a pin sample needs to reach the third sync stage after reset
    localparam logic [1:0] SYNC_FILL    = 2'h3;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] shdw;
        logic [31:0] reload;
        logic [7:0]  flag;
        logic [7:0]  enab;
        logic [23:0] prio;
        logic [2:0]  sripl;
        logic [7:0]  sirq;
        logic [31:0] cnt;
        logic        run;
        logic        done;
        logic        req;
        logic [7:0]  num;
        logic [2:0]  lvl;
        logic [17:0] off;
        logic        shadow;
        logic [31:0] rdata;
    } vicr_state_s;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] lvl;
        logic       primed;
        logic [1:0] fill;
        logic [4:0] pulse;
    } vicr_edge_state_s;

endpackage

// ==== vicr_edge_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface vicr_edge_if;
    logic [4:0] polarity;
    logic [4:0] edge_pulse;
    // Controller side
    modport ctl (output polarity, input edge_pulse);
    // Edge detector side
    modport det (input polarity, output edge_pulse);
endinterface
`default_nettype wire

// ==== vicr_ext_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
module vicr_ext_edge
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // External interrupt pins
    input  wire logic [4:0] i_pin,
    // Polarity in, edge pulses out
    vicr_edge_if.det        eif
);
    vicr_pkg::vicr_edge_state_s st_ff;
    vicr_pkg::vicr_edge_state_s nxt_st;

    // Three-stage sync; level accepted once stages two and three agree
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.s1 = i_pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.pulse = 5'h00;
        if (!st_ff.primed)
        begin
            // Stage three holds the reset zero until the pipe has filled;
            // priming on it would turn a pin idling high into a false edge
            if (st_ff.fill != vicr_pkg::SYNC_FILL)
                nxt_st.fill = st_ff.fill + 2'h1;
            // First agreed level after that is taken without an edge
            else if (st_ff.s2 == st_ff.s3)
            begin
                nxt_st.lvl    = st_ff.s3;
                nxt_st.primed = 1'b1;
            end
        end
        else
        begin
            for (int i = 0; i < vicr_pkg::NUM_EXT; i++)
            begin
                if (st_ff.s2[i] == st_ff.s3[i] && st_ff.s3[i] != st_ff.lvl[i])
                begin
                    nxt_st.lvl[i]   = st_ff.s3[i];
                    nxt_st.pulse[i] = (st_ff.s3[i] == eif.polarity[i]);
                end
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign eif.edge_pulse = st_ff.pulse;

    property p_rise_edge;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_ff.primed && st_ff.s2[0] && st_ff.s3[0] && !st_ff.lvl[0] && eif.polarity[0])
            |=> st_ff.pulse[0];
    endproperty
    a_rise_edge: assert property (p_rise_edge)
        else $error("rising edge on pin 0 gave no pulse");

    property p_fall_ignored;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_ff.primed && st_ff.s3[1] && !st_ff.lvl[1] && !eif.polarity[1])
            |=> !st_ff.pulse[1];
    endproperty
    a_fall_ignored: assert property (p_fall_ignored)
        else $error("rising edge on falling-polarity pin 1 gave a pulse");
endmodule // vicr_ext_edge
`default_nettype wire

// ==== vicr_ctrl.sv ====
//
// Summary of operation
// - One-hot spacing code gives 0, 8, 16 ... 512 bytes between vectors.
// - Single-vector mode ignores the spacing setting.
// - Mode bit set gives one vector per source, clear gives one shared vector.
// - Threshold N of 2..7 lets priority N or lower start the timer.
// - Threshold 1 lets only priority 1 start the timer.
// - Threshold 0 disables the proximity timer completely.
// - Each external input has a polarity bit: set rising, clear falling.
// - Per-level four-bit field picks shadow set 0 or 1; other codes reserved.
// - Single-vector shadow bit decides whether the shared vector gets a shadow set.
// - Status holds the priority level of the latest presented interrupt.
// - Status holds the number of the last request serviced by the core.
// - The timer loads the 32-bit reload value whenever an event starts it.
// - Unimplemented bits ignore writes and read as zero.
// - Clear, set and invert aliases sit at plus 4, 8 and C.
// - Each source flag reads one once its request occurred.
// - Source priority 0 disables it; 1 to 7 are priority levels.
`timescale 1ns/1ps
`default_nettype none
module vicr_ctrl
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Interrupt sources
    input  wire logic [4:0]  i_ext_irq,
    input  wire logic [2:0]  i_int_evt,
    // Request to the core
    output logic             o_irq_req,
    output logic      [7:0]  o_irq_num,
    output logic      [2:0]  o_irq_level,
    output logic      [17:0] o_irq_vec_off,
    output logic             o_irq_shadow,
    input  wire logic        i_irq_ack
);
    vicr_pkg::vicr_state_s st_ff;
    vicr_pkg::vicr_state_s nxt_st;

    logic        cand_v;
    logic [2:0]  cand_i;
    logic [2:0]  cand_l;
    logic        qual;
    logic        present;
    logic [1:0]  wop;
    logic [7:0]  wbase;
    logic [7:0]  flag_n;
    logic [7:0]  ev;
    logic [9:0]  bytes;
    logic [3:0]  ss_fld;

    vicr_edge_if eif ();

    // Masked write through one of the four aliases
    function automatic logic [31:0] wr_apply(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [1:0] op, input logic [31:0] mask);
        logic [31:0] m;
        m = wd & mask;
        unique case (op)
            vicr_pkg::OP_WR:  wr_apply = (old & ~mask) | m;
            vicr_pkg::OP_CLR: wr_apply = old & ~m;
            vicr_pkg::OP_SET: wr_apply = old | m;
            vicr_pkg::OP_INV: wr_apply = old ^ m;
        endcase
    endfunction

    // One-hot spacing code to bytes; reserved codes give zero
    function automatic logic [9:0] spacing_bytes(input logic [6:0] vs);
        spacing_bytes = 10'h000;
        for (int k = 0; k < vicr_pkg::VS_W; k++)
        begin
            if (vs == 7'(7'h01 << k))
                spacing_bytes = 10'(vicr_pkg::SPACING_UNIT << k);
        end
    endfunction

    // Does a request of this level start the proximity timer
    function automatic logic tpc_hit(input logic [2:0] tpc, input logic [2:0] lvl);
        if (tpc == 3'h0)
            tpc_hit = 1'b0;
        else if (tpc == 3'h1)
            tpc_hit = (lvl == 3'h1);
        else
            tpc_hit = (lvl <= tpc);
    endfunction

    // Edge detector for the external pins
    assign eif.polarity = st_ff.ctrl[4:0];

    vicr_ext_edge i_vicr_ext_edge
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_ext_irq),
        .eif       (eif)
    );

    // Highest pending priority; lower source number wins a tie
    always_comb
    begin
        cand_v = 1'b0;
        cand_i = 3'h0;
        cand_l = 3'h0;
        for (int i = vicr_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (st_ff.flag[i] && st_ff.enab[i] && st_ff.prio[i*3 +: 3] != 3'h0
                && st_ff.prio[i*3 +: 3] >= cand_l)
            begin
                cand_v = 1'b1;
                cand_i = 3'(i);
                cand_l = st_ff.prio[i*3 +: 3];
            end
        end
    end

    // Derived terms shared by next-state logic and checks
    assign qual    = cand_v && tpc_hit(st_ff.ctrl[vicr_pkg::TPC_LSB +: 3], cand_l);
    assign present = cand_v && (!qual || st_ff.done);
    assign wop     = i_addr[3:2];
    assign wbase   = {i_addr[7:4], 4'h0};
    assign ev      = {i_int_evt, eif.edge_pulse};
    assign bytes   = spacing_bytes(st_ff.ctrl[vicr_pkg::VS_LSB +: vicr_pkg::VS_W]);
    assign ss_fld  = st_ff.shdw[cand_l*vicr_pkg::SHDW_FLD_W +: vicr_pkg::SHDW_FLD_W];

    // Next state of the whole controller
    always_comb
    begin
        nxt_st = st_ff;
        // Register writes; status is read-only and ignores them
        if (i_wr)
        begin
            case (wbase)
                vicr_pkg::OFS_CTRL:
                    nxt_st.ctrl = wr_apply(st_ff.ctrl, i_wdata, wop, vicr_pkg::CTRL_MASK);
                vicr_pkg::OFS_SHDW:
                    nxt_st.shdw = wr_apply(st_ff.shdw, i_wdata, wop, vicr_pkg::SHDW_MASK);
                vicr_pkg::OFS_RELOAD:
                    nxt_st.reload = wr_apply(st_ff.reload, i_wdata, wop, vicr_pkg::RELOAD_MASK);
                vicr_pkg::OFS_FLAG:
                    nxt_st.flag = 8'(wr_apply(32'(st_ff.flag), i_wdata, wop, vicr_pkg::SRC_MASK));
                vicr_pkg::OFS_ENAB:
                    nxt_st.enab = 8'(wr_apply(32'(st_ff.enab), i_wdata, wop, vicr_pkg::SRC_MASK));
                vicr_pkg::OFS_PRIO:
                    nxt_st.prio = 24'(wr_apply(32'(st_ff.prio), i_wdata, wop, vicr_pkg::PRIO_MASK));
                default:
                    nxt_st.prio = st_ff.prio;
            endcase
        end

        // Flags: ack clears the serviced source, a new event wins over any clear
        flag_n = nxt_st.flag;
        if (i_irq_ack && st_ff.req)
        begin
            flag_n[st_ff.num[2:0]] = 1'b0;
            nxt_st.sirq = st_ff.num;
        end
        nxt_st.flag = flag_n | ev;

        // Proximity timer; dropping the qualifying request abandons it
        if (!qual)
        begin
            nxt_st.run  = 1'b0;
            nxt_st.done = 1'b0;
        end
        else if (st_ff.run)
        begin
            if (st_ff.cnt == 32'h00000000)
            begin
                nxt_st.run  = 1'b0;
                nxt_st.done = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt - 32'h00000001;
        end
        else if (!st_ff.done)
        begin
            nxt_st.run = 1'b1;
            nxt_st.cnt = st_ff.reload;
        end

        // Request to the core, updated while one is presented
        nxt_st.req = present;
        if (present)
        begin
            nxt_st.num   = 8'(cand_i);
            nxt_st.lvl   = cand_l;
            nxt_st.sripl = cand_l;
            if (st_ff.ctrl[vicr_pkg::MULTI_VECTOR_SELECT_BIT])
            begin
                nxt_st.off    = 18'(cand_i) * 18'(bytes);
                nxt_st.shadow = ss_fld[0];
            end
            else
            begin
                nxt_st.off    = 18'h00000;
                nxt_st.shadow = st_ff.shdw[vicr_pkg::SS0_BIT];
            end
        end

        // Read data stands only in the cycle after the strobe
        nxt_st.rdata = 32'h00000000;
        if (i_rd)
        begin
            case (wbase)
                vicr_pkg::OFS_CTRL:   nxt_st.rdata = st_ff.ctrl;
                vicr_pkg::OFS_SHDW:   nxt_st.rdata = st_ff.shdw;
                vicr_pkg::OFS_STAT:   nxt_st.rdata = {21'h000000, st_ff.sripl, st_ff.sirq};
                vicr_pkg::OFS_RELOAD: nxt_st.rdata = st_ff.reload;
                vicr_pkg::OFS_FLAG:   nxt_st.rdata = {24'h000000, st_ff.flag};
                vicr_pkg::OFS_ENAB:   nxt_st.rdata = {24'h000000, st_ff.enab};
                vicr_pkg::OFS_PRIO:   nxt_st.rdata = {8'h00, st_ff.prio};
                default:              nxt_st.rdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_ff        <= '0;
            st_ff.ctrl   <= vicr_pkg::CTRL_RST;
            st_ff.shdw   <= vicr_pkg::SHDW_RST;
            st_ff.reload <= vicr_pkg::RELOAD_RST;
        end
        else
            st_ff <= nxt_st;
    end

    // Outputs straight from the state register
    assign o_rdata       = st_ff.rdata;
    assign o_irq_req     = st_ff.req;
    assign o_irq_num     = st_ff.num;
    assign o_irq_level   = st_ff.lvl;
    assign o_irq_vec_off = st_ff.off;
    assign o_irq_shadow  = st_ff.shadow;

    property p_tpc_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_ff.ctrl[vicr_pkg::TPC_LSB +: 3] == 3'h0) |-> !qual;
    endproperty
    a_tpc_off: assert property (p_tpc_off)
        else $error("timer qualified while disabled");

    property p_multi_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        (present && st_ff.ctrl[vicr_pkg::MULTI_VECTOR_SELECT_BIT])
            |=> (o_irq_vec_off == 18'($past(cand_i)) * 18'($past(bytes)));
    endproperty
    a_multi_off: assert property (p_multi_off)
        else $error("vector offset is not number times spacing");

    property p_single_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        (present && !st_ff.ctrl[vicr_pkg::MULTI_VECTOR_SELECT_BIT]) |=> (o_irq_vec_off == 18'h00000) && o_irq_req;
    endproperty
    a_single_off: assert property (p_single_off)
        else $error("single vector offset not zero");

    property p_stat_zero;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && wbase == vicr_pkg::OFS_STAT) |=> (o_rdata[31:11] == 21'h000000);
    endproperty
    a_stat_zero: assert property (p_stat_zero)
        else $error("unimplemented status bits read nonzero");

    property p_ack_sirq;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_irq_ack && o_irq_req) |=> (st_ff.sirq == $past(o_irq_num));
    endproperty
    a_ack_sirq: assert property (p_ack_sirq)
        else $error("serviced number not recorded");

    property p_reload;
        @(posedge i_clk) disable iff (i_sys_rst)
        (qual && !st_ff.run && !st_ff.done) |=> (st_ff.run && st_ff.cnt == $past(st_ff.reload));
    endproperty
    a_reload: assert property (p_reload)
        else $error("timer did not load reload value");

    property p_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (qual && !st_ff.done) |=> !o_irq_req;
    endproperty
    a_hold: assert property (p_hold)
        else $error("qualifying request presented before timer expiry");

    property p_set_alias;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr && wbase == vicr_pkg::OFS_CTRL && wop == vicr_pkg::OP_SET)
            |=> (st_ff.ctrl == ($past(st_ff.ctrl) | ($past(i_wdata) & vicr_pkg::CTRL_MASK)));
    endproperty
    a_set_alias: assert property (p_set_alias)
        else $error("set alias did not OR into control");

    property p_level;
        @(posedge i_clk) disable iff (i_sys_rst)
        present |=> (st_ff.sripl == $past(cand_l)) && (o_irq_level == st_ff.sripl);
    endproperty
    a_level: assert property (p_level)
        else $error("requested level status mismatch");

    // Reserved select codes are left out; only 0000 and 0001 are defined
    property p_multi_shadow;
        @(posedge i_clk) disable iff (i_sys_rst)
        (present && st_ff.ctrl[vicr_pkg::MULTI_VECTOR_SELECT_BIT] && ss_fld[3:1] == 3'h0)
            |=> (o_irq_shadow == $past(ss_fld == 4'h1));
    endproperty
    a_multi_shadow: assert property (p_multi_shadow)
        else $error("level shadow select not applied");

    property p_single_shadow;
        @(posedge i_clk) disable iff (i_sys_rst)
        (present && !st_ff.ctrl[vicr_pkg::MULTI_VECTOR_SELECT_BIT])
            |=> (o_irq_shadow == $past(st_ff.shdw[vicr_pkg::SS0_BIT]));
    endproperty
    a_single_shadow: assert property (p_single_shadow)
        else $error("single vector shadow bit not applied");

    property p_tpc_one;
        @(posedge i_clk) disable iff (i_sys_rst)
        (st_ff.ctrl[vicr_pkg::TPC_LSB +: 3] == 3'h1 && cand_l != 3'h1) |-> !qual;
    endproperty
    a_tpc_one: assert property (p_tpc_one)
        else $error("threshold one qualified a level other than one");

    // A source event must win over any clear in the same cycle
    property p_flag_set;
        @(posedge i_clk) disable iff (i_sys_rst)
        (ev != 8'h00) |=> ((st_ff.flag & $past(ev)) == $past(ev));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("source event did not set its flag");
endmodule // vicr_ctrl
`default_nettype wire

// ==== vicr_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vicr_core_model
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // Bench control
    input  wire logic       i_en,
    input  wire logic [3:0] i_delay,
    // Request from the controller
    input  wire logic       i_irq_req,
    output logic            o_irq_ack
);
    logic [3:0] wait_cnt;
    logic [1:0] guard;

    // One ack per request; guard spans the cycles until req falls
    always @(posedge i_clk)
    begin
        o_irq_ack <= 1'b0;
        if (i_sys_rst)
        begin
            wait_cnt <= 4'h0;
            guard    <= 2'h0;
        end
        else if (guard != 2'h0)
            guard <= guard - 2'h1;
        else if (i_en && i_irq_req)
        begin
            if (wait_cnt == i_delay)
            begin
                o_irq_ack <= 1'b1;
                wait_cnt  <= 4'h0;
                guard     <= 2'h3;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
        else
            wait_cnt <= 4'h0;
    end
endmodule // vicr_core_model
`default_nettype wire

// ==== tb_vicr_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_vicr_ctrl;
    logic        clk, rst, wr, rd, req, shadow, ack, core_en;
    logic [7:0]  addr, num;
    logic [31:0] wdata, rdata;
    logic [4:0]  ext;
    logic [2:0]  evt, level;
    logic [17:0] vec_off;
    logic [3:0]  delay;
    int          fail_count, n_checks;

    vicr_ctrl i_vicr_ctrl (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_irq(ext), .i_int_evt(evt),
        .o_irq_req(req), .o_irq_num(num), .o_irq_level(level), .o_irq_vec_off(vec_off),
        .o_irq_shadow(shadow), .i_irq_ack(ack));
    vicr_core_model i_vicr_core_model (.i_clk(clk), .i_sys_rst(rst), .i_en(core_en),
        .i_delay(delay), .i_irq_req(req), .o_irq_ack(ack));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One-cycle bus strobes, launched right after an edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask

    // Pulse an internal event, count edges until the request shows
    task automatic fire(input int src, output int n);
        @(posedge clk);
        evt <= 3'h1 << (src - 5);
        @(posedge clk);
        evt <= 3'h0;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (req !== 1'b1 && n < 100);
    endtask

    // Let the core model ack, then wait for the request to drop
    task automatic service();
        int n;
        n = 0;
        @(posedge clk);
        core_en <= 1'b1;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (req !== 1'b0 && n < 30);
        check("req_drop", req, 1'b0);
        @(posedge clk);
        core_en <= 1'b0;
    endtask

    task automatic t_regs();
        rd_chk("ctrl_rst", 8'h00, 32'h0);
        rd_chk("shdw_rst", 8'h10, 32'h0);
        rd_chk("stat_rst", 8'h20, 32'h0);
        rd_chk("reload_rst", 8'h30, 32'h0);
        wr_reg(8'h00, 32'hFFC0FFFF);
        rd_chk("ctrl_mask", 8'h00, 32'h0040171F);
        wr_reg(8'h10, 32'h1111111F);
        rd_chk("shdw_mask", 8'h10, 32'h11111111);
        wr_reg(8'h20, 32'hFFFFFFFF);
        rd_chk("stat_ro", 8'h20, 32'h0);
        wr_reg(8'h30, 32'hA5A55A5A);
        rd_chk("reload", 8'h30, 32'hA5A55A5A);
        rd_chk("unmapped", 8'h70, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_alias();
        wr_reg(8'h00, 32'h1003);
        wr_reg(8'h08, 32'h0004);
        rd_chk("ctrl_set", 8'h00, 32'h1007);
        wr_reg(8'h04, 32'h1001);
        rd_chk("ctrl_clr", 8'h00, 32'h0006);
        wr_reg(8'h0C, 32'h0003);
        rd_chk("ctrl_inv", 8'h00, 32'h0005);
        $display("test alias done");
    endtask

    // Source 5 at level 3 through every spacing code, then single mode
    task automatic t_vector();
        logic [31:0] code;
        int          n;
        wr_reg(8'h60, 32'h3 << 15);
        wr_reg(8'h50, 32'h20);
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(8'h10, 32'(k % 2) << 12);
            code = (k == 0) ? 32'h0 : 32'h1 << (k - 1);
            wr_reg(8'h00, 32'h1000 | (code << 16));
            fire(5, n);
            check("latency", n, 1);
            check("num", num, 5);
            check("level", level, 3);
            check("shadow", shadow, 32'(k % 2));
            check("vec_off", vec_off, (k == 0) ? 0 : 5 * (8 << (k - 1)));
            service();
            rd_chk("status", 8'h20, 32'h0305);
        end
        delay <= 4'h4;
        for (int s = 0; s < 2; s++)
        begin
            wr_reg(8'h10, s);
            wr_reg(8'h00, 32'h00400000);
            fire(5, n);
            check("single_off", vec_off, 0);
            check("single_shadow", shadow, s);
            service();
            rd_chk("single_stat", 8'h20, 32'h0305);
        end
        delay <= 4'h0;
        $display("test vector done");
    endtask

    // Threshold against source level, reload of five cycles
    task automatic t_timer();
        int thr [6] = '{0, 1, 1, 3, 3, 7};
        int pri [6] = '{1, 1, 2, 3, 4, 7};
        int qual [6] = '{0, 1, 0, 1, 0, 1};
        int n;
        wr_reg(8'h30, 32'h5);
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(8'h00, 32'h1000 | (thr[i] << 8));
            wr_reg(8'h60, pri[i] << 15);
            fire(5, n);
            check("timer_lat", n, qual[i] ? 8 : 1);
            service();
        end
        $display("test timer done");
    endtask

    // Alternate polarities; flags show which edges counted
    task automatic t_polarity();
        wr_reg(8'h50, 32'h0);
        wr_reg(8'h00, 32'h15);
        wr_reg(8'h44, 32'h1F);
        repeat (10) @(posedge clk);
        ext <= 5'h1F;
        repeat (10) @(posedge clk);
        rd_chk("rise_flags", 8'h40, 32'h15);
        wr_reg(8'h44, 32'h1F);
        ext <= 5'h00;
        repeat (10) @(posedge clk);
        rd_chk("fall_flags", 8'h40, 32'h0A);
        wr_reg(8'h44, 32'h1F);
        $display("test polarity done");
    endtask

    // Priority zero keeps an enabled, flagged source silent
    task automatic t_disabled();
        wr_reg(8'h60, 32'h0);
        wr_reg(8'h50, 32'h40);
        @(posedge clk);
        evt <= 3'h2;
        @(posedge clk);
        evt <= 3'h0;
        repeat (6) @(posedge clk);
        #1;
        check("prio0_req", req, 1'b0);
        rd_chk("prio0_flag", 8'h40, 32'h40);
        wr_reg(8'h44, 32'h40);
        $display("test disabled done");
    endtask

    // Mid-run reset with pins high: no false edge, later falls still count
    task automatic t_reset();
        @(posedge clk);
        ext <= 5'h1F;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rd_chk("rst_flags", 8'h40, 32'h0);
        @(posedge clk);
        ext <= 5'h00;
        repeat (10) @(posedge clk);
        rd_chk("rst_fall", 8'h40, 32'h1F);
        $display("test reset done");
    endtask

    // Main sequence
    initial
    begin
        rst        = 1'b1;
        wr         = 1'b0;
        rd         = 1'b0;
        addr       = 8'h00;
        wdata      = 32'h0;
        ext        = 5'h00;
        evt        = 3'h0;
        core_en    = 1'b0;
        delay      = 4'h0;
        fail_count = 0;
        n_checks   = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_alias();
        t_vector();
        t_timer();
        t_polarity();
        t_disabled();
        t_reset();
        stop_test();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        #100000;
        fail_count++;
        $display("timeout");
        stop_test();
    end
endmodule // tb_vicr_ctrl
`default_nettype wire
